// file: design/iisr_regs.sv
/*
  Identification, interrupt status and receive configuration registers
  behind an AXI4-Lite slave, with the MAC reset watchdog.
  Assumes event pulses come from logic on clock_i; PHY clocks, PHY
  interrupt lines and pins are asynchronous and are synchronised here.
*/
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "iisr_defs.svh"

module iisr_regs #(
  parameter logic [15:0] DEVICE_MODEL = 16'h5A3C, // arbitrary value
  parameter logic [15:0] DEVICE_REVISION = 16'h0001, // arbitrary value
  parameter int WD_CYCLES = `IISR_MAC_WD_CYCLES
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [`IISR_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output iisr_pkg::iisr_resp_t s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`IISR_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output iisr_pkg::iisr_resp_t s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic mac_reset_req_i,
  input wire logic phy_rx_clk_i,
  input wire logic phy_tx_clk_i,
  input wire logic int_phy_irq_i,
  input wire logic ext_phy_irq_i,
  input wire logic tx_halted_pulse_i,
  input wire logic rx_halted_pulse_i,
  input wire logic tx_error_pulse_i,
  input wire logic tx_underrun_pulse_i,
  input wire logic tx_overrun_pulse_i,
  input wire logic rx_drop_pulse_i,
  input wire logic [`IISR_PIN_COUNT-1:0] gpio_pin_i,
  input wire logic [`IISR_PIN_COUNT-1:0] gpio_int_en_i,
  output logic mac_reset_o,
  output logic rx_fifo_flush_o,
  output logic [`IISR_PIN_COUNT-1:0] pin_wake_o
);
  import iisr_pkg::*;

  localparam int NSYNC = `IISR_PIN_COUNT + 4;
  localparam int SEL_RX_CLK = `IISR_PIN_COUNT + 2;
  localparam int SEL_TX_CLK = `IISR_PIN_COUNT + 3;
  localparam int SEL_INT_IRQ = `IISR_PIN_COUNT;
  localparam int SEL_EXT_IRQ = `IISR_PIN_COUNT + 1;

  // asynchronous inputs: three stages, a change counts once 2 and 3 agree
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync3_reg;
  logic [NSYNC-1:0] stable_reg;

  assign pins_raw = {phy_tx_clk_i, phy_rx_clk_i, ext_phy_irq_i, int_phy_irq_i, gpio_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      // no reset on the chain: a pin level has no meaningful constant
      always_ff @(posedge clock_i)
      begin
        if (ce_i)
        begin
          sync1_reg[gi] <= pins_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (srst_i || (sync2_reg[gi] == sync3_reg[gi]))
            stable_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  endgenerate

  // a PHY clock counts as running once its filtered level changes
  logic phy_clk_seen;
  assign phy_clk_seen =
    ((sync2_reg[SEL_RX_CLK] == sync3_reg[SEL_RX_CLK]) &&
     (sync3_reg[SEL_RX_CLK] != stable_reg[SEL_RX_CLK])) ||
    ((sync2_reg[SEL_TX_CLK] == sync3_reg[SEL_TX_CLK]) &&
     (sync3_reg[SEL_TX_CLK] != stable_reg[SEL_TX_CLK]));

  // write channel
  logic aw_held_reg;
  logic w_held_reg;
  logic [`IISR_ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;
  logic [31:0] wmask;
  logic wr_sts;
  logic wr_rx_cfg;
  logic wr_ctrl;
  logic wr_known;

  assign wr_go = ce_i && aw_held_reg && w_held_reg && !s_axi_bvalid_o;
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_sts = waddr_reg[7:2] == 6'(`IISR_INTERRUPT_EVENT_STATUS_OFFSET >> 2);
  assign wr_rx_cfg = waddr_reg[7:2] == 6'(`IISR_RECEIVE_CONFIGURATION_OFFSET >> 2);
  assign wr_ctrl = waddr_reg[7:2] == 6'(`IISR_BLOCK_CONTROL_OFFSET >> 2);
  assign wr_known = wr_sts || wr_rx_cfg || wr_ctrl ||
    (waddr_reg[7:2] == 6'(`IISR_DEVICE_IDENTITY_REVISION_OFFSET >> 2));

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `IISR_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // writes to the read-only id word are accepted and dropped
        s_axi_bresp_o <= wr_known ? `IISR_RESP_OKAY : `IISR_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // control register: PHY interrupt source select
  logic phy_sel_reg;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      phy_sel_reg <= `IISR_PHY_SELECT_RESET;
    else if (wr_go && wr_ctrl && wstrb_reg[0])
      phy_sel_reg <= wdata_reg[`IISR_PHY_SELECT_BIT];
  end

  logic phy_flag;
  assign phy_flag = phy_sel_reg ? stable_reg[SEL_EXT_IRQ] : stable_reg[SEL_INT_IRQ];

  // receive FIFO flush: one-cycle pulse, register bit reads back 0 after
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      rx_fifo_flush_o <= `IISR_RX_FLUSH_RESET;
    else if (ce_i)
      rx_fifo_flush_o <= wr_go && wr_rx_cfg && wstrb_reg[0] && wdata_reg[`IISR_RX_FLUSH_BIT];
  end

  // MAC reset watchdog
  iisr_wd_state_e wd_state_reg;
  logic [`IISR_WD_COUNT_W-1:0] wd_count_reg;
  logic wd_expire;

  assign wd_expire = (wd_state_reg == WD_WAIT) && !phy_clk_seen &&
    (wd_count_reg == `IISR_WD_COUNT_W'(WD_CYCLES - 1));

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      wd_state_reg <= WD_IDLE;
      wd_count_reg <= '0;
      mac_reset_o <= `IISR_MAC_RESET_RESET;
    end
    else if (ce_i)
    begin
      case (wd_state_reg)
        WD_IDLE:
        begin
          if (mac_reset_req_i)
          begin
            wd_state_reg <= WD_WAIT;
            wd_count_reg <= '0;
            mac_reset_o <= 1'b1;
          end
        end
        WD_WAIT:
        begin
          // expiry releases the reset without any PHY clock edge
          if (phy_clk_seen || wd_expire)
          begin
            wd_state_reg <= WD_IDLE;
            mac_reset_o <= 1'b0;
          end
          else
            wd_count_reg <= wd_count_reg + 1'b1;
        end
        default:
          wd_state_reg <= WD_IDLE;
      endcase
    end
  end

  // sticky status flags; bit 15 is not stored
  logic [`IISR_STATUS_MSB:0] flags_reg;
  logic [`IISR_STATUS_MSB:0] flags_set;
  logic [`IISR_STATUS_MSB:0] flags_clr;
  logic [`IISR_PIN_COUNT-1:0] pin_level;

  assign pin_level = stable_reg[`IISR_PIN_COUNT-1:0] & gpio_int_en_i;

  always_comb
  begin
    flags_set = '0;
    flags_set[`IISR_MAC_RESET_TIMEOUT_FLAG] = wd_expire;
    flags_set[`IISR_TRANSMIT_HALTED_FLAG] = tx_halted_pulse_i;
    flags_set[`IISR_RECEIVE_HALTED_FLAG] = rx_halted_pulse_i;
    flags_set[`IISR_TRANSMIT_ERROR_FLAG] = tx_error_pulse_i;
    flags_set[`IISR_TX_FIFO_UNDERRUN_FLAG] = tx_underrun_pulse_i;
    flags_set[`IISR_TX_FIFO_OVERRUN_FLAG] = tx_overrun_pulse_i;
    flags_set[`IISR_RX_FRAME_DROPPED_FLAG] = rx_drop_pulse_i;
    flags_set[`IISR_PIN_COUNT-1:0] = pin_level;
  end

  assign flags_clr = (wr_go && wr_sts) ? wdata_reg[`IISR_STATUS_MSB:0] &
    wmask[`IISR_STATUS_MSB:0] : '0;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      flags_reg[`IISR_STATUS_MSB:`IISR_PIN_COUNT] <= `IISR_EVENT_FLAGS_RESET;
      flags_reg[`IISR_PIN_COUNT-1:0] <= sync3_reg[`IISR_PIN_COUNT-1:0] & gpio_int_en_i;
    end
    else if (ce_i)
    begin
      // set beats clear so an event in the clearing cycle survives
      flags_reg <= flags_set | (flags_reg & ~flags_clr);
      flags_reg[`IISR_PHY_EVENT_FLAG] <= 1'b0;
    end
  end

  // wake events per pin, cleared together with the pin flag
  logic [`IISR_PIN_COUNT-1:0] wake_clr_only;
  assign wake_clr_only = flags_clr[`IISR_PIN_COUNT-1:0] & ~pin_level;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      pin_wake_o <= '0;
    else if (ce_i)
      pin_wake_o <= pin_level | (pin_wake_o & ~flags_clr[`IISR_PIN_COUNT-1:0]);
  end

  // read channel: data sampled at the address handshake
  logic [31:0] sts_word;
  logic [31:0] rd_word;
  logic rd_known;

  always_comb
  begin
    sts_word = '0;
    sts_word[`IISR_STATUS_MSB:0] = flags_reg;
    sts_word[`IISR_PHY_EVENT_FLAG] = phy_flag;
    rd_known = 1'b1;
    case (s_axi_araddr_i[7:2])
      6'(`IISR_DEVICE_IDENTITY_REVISION_OFFSET >> 2): rd_word = {DEVICE_MODEL, DEVICE_REVISION};
      6'(`IISR_INTERRUPT_EVENT_STATUS_OFFSET >> 2): rd_word = sts_word;
      6'(`IISR_RECEIVE_CONFIGURATION_OFFSET >> 2): rd_word = {31'h0, rx_fifo_flush_o};
      6'(`IISR_BLOCK_CONTROL_OFFSET >> 2): rd_word = {31'h0, phy_sel_reg};
      default:
      begin
        rd_word = '0;
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= `IISR_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_word;
        s_axi_rresp_o <= rd_known ? `IISR_RESP_OKAY : `IISR_RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // checks
  a_id_readback: assert property (@(posedge clock_i) disable iff (srst_i)
    (ce_i && s_axi_arvalid_i && s_axi_arready_o &&
     s_axi_araddr_i[7:2] == 6'h00) |=> s_axi_rdata_o == {DEVICE_MODEL, DEVICE_REVISION})
    else $error("id word read back wrong");

  a_sts_reserved_zero: assert property (@(posedge clock_i) disable iff (srst_i)
    (ce_i && s_axi_arvalid_i && s_axi_arready_o &&
     s_axi_araddr_i[7:2] == 6'h02) |=> s_axi_rdata_o[31:19] == 13'h0)
    else $error("status reserved bits not zero");

  a_timeout_flag_set: assert property (@(posedge clock_i) disable iff (srst_i)
    (ce_i && wd_expire) |=> flags_reg[18] && !mac_reset_o)
    else $error("watchdog expiry did not set flag or release reset");

  a_wd_bound: assert property (@(posedge clock_i) disable iff (srst_i)
    (wd_state_reg == WD_WAIT) |-> wd_count_reg < `IISR_WD_COUNT_W'(WD_CYCLES))
    else $error("watchdog ran past its limit");

  a_sticky_holds: assert property (@(posedge clock_i) disable iff (srst_i)
    (ce_i && flags_reg[17] && !flags_clr[17]) |=> flags_reg[17])
    else $error("sticky flag lost without a clear");

  a_phy_source: assert property (@(posedge clock_i) disable iff (srst_i)
    (ce_i && s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:2] == 6'h02)
    |=> s_axi_rdata_o[15] == $past(phy_flag))
    else $error("phy flag read wrong source");

  a_event_beats_clear: assert property (@(posedge clock_i) disable iff (srst_i)
    (ce_i && tx_error_pulse_i && flags_clr[14]) |=> flags_reg[14])
    else $error("event lost against clear");

  a_clear_works: assert property (@(posedge clock_i) disable iff (srst_i)
    (ce_i && flags_clr[11] && !rx_drop_pulse_i) |=> !flags_reg[11])
    else $error("write one did not clear");

  a_flush_one_cycle: assert property (@(posedge clock_i) disable iff (srst_i)
    (rx_fifo_flush_o && ce_i) |=> !rx_fifo_flush_o)
    else $error("flush pulse longer than one cycle");

  a_wake_cleared: assert property (@(posedge clock_i) disable iff (srst_i)
    (ce_i && wake_clr_only != '0) |=> (pin_wake_o & $past(wake_clr_only)) == '0)
    else $error("wake event survived pin flag clear");

endmodule : iisr_regs

// file: include/iisr_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the
  identification, interrupt status and receive configuration slice.
  Assumes byte addresses on an 8-bit AXI4-Lite address, word aligned.
*/
`ifndef IISR_DEFS_SVH
`define IISR_DEFS_SVH

`define IISR_ADDR_W 8
`define IISR_DEVICE_IDENTITY_REVISION_OFFSET 8'h00
`define IISR_INTERRUPT_EVENT_STATUS_OFFSET 8'h08
`define IISR_RECEIVE_CONFIGURATION_OFFSET 8'h0C
`define IISR_BLOCK_CONTROL_OFFSET 8'h40

`define IISR_STATUS_MSB 18
`define IISR_MAC_RESET_TIMEOUT_FLAG 18
`define IISR_TRANSMIT_HALTED_FLAG 17
`define IISR_RECEIVE_HALTED_FLAG 16
`define IISR_PHY_EVENT_FLAG 15
`define IISR_TRANSMIT_ERROR_FLAG 14
`define IISR_TX_FIFO_UNDERRUN_FLAG 13
`define IISR_TX_FIFO_OVERRUN_FLAG 12
`define IISR_RX_FRAME_DROPPED_FLAG 11
`define IISR_PIN_COUNT 11
`define IISR_RX_FLUSH_BIT 0
`define IISR_PHY_SELECT_BIT 0

`define IISR_EVENT_FLAGS_RESET 8'h00
`define IISR_RX_FLUSH_RESET 1'b0
`define IISR_PHY_SELECT_RESET 1'b0
`define IISR_MAC_RESET_RESET 1'b0

`define IISR_CLOCK_HZ 20000000
`define IISR_MAC_WD_TIME_MS 8
`define IISR_MAC_WD_CYCLES ((`IISR_MAC_WD_TIME_MS * `IISR_CLOCK_HZ) / 1000)
`define IISR_WD_COUNT_W 18

`define IISR_RESP_OKAY 2'h0
`define IISR_RESP_SLVERR 2'h2

`endif

// file: include/iisr_pkg.sv
/*
  Types of the identification and interrupt status slice.
  Assumes iisr_defs.svh is on the include path.
*/
package iisr_pkg;
  typedef logic [1:0] iisr_resp_t;
  typedef enum logic {WD_IDLE, WD_WAIT} iisr_wd_state_e;
endpackage : iisr_pkg

// file: bench/testbench.sv
/*
  Self-checking bench for the id, status and rx config register slice.
  Assumes iisr_defs.svh on the include path; ce_i is high but for one freeze test.
*/
`timescale 1ns/1ps
`include "iisr_defs.svh"

module testbench;
  import iisr_pkg::*;
  localparam int WD = 50; // short watchdog keeps the run brief
  localparam logic [15:0] MODEL = 16'h3C5A; // arbitrary value
  localparam logic [15:0] REV = 16'h0007; // arbitrary value
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] ERR = 2'h2;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic mac_req = 1'b0, rx_clk = 1'b0, int_irq = 1'b0, ext_irq = 1'b0;
  logic ce = 1'b1, tx_clk = 1'b0;
  logic [3:0] strb = 4'hF;
  logic [17:11] ev = 7'h00;
  logic [10:0] pins = 11'h000, en = 11'h000;
  logic awready, wready, bvalid, arready, rvalid, mac_rst, flush;
  iisr_resp_t bresp, rresp;
  logic [31:0] rdata, exp_s, d;
  logic [10:0] wake;
  int num_errors = 0, checks = 0, flush_cnt = 0, n, f0, seed;

  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) if (flush === 1'b1) flush_cnt <= flush_cnt + 1;

  iisr_regs #(.DEVICE_MODEL(MODEL), .DEVICE_REVISION(REV), .WD_CYCLES(WD)) i_dut (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .mac_reset_req_i(mac_req),
    .phy_rx_clk_i(rx_clk), .phy_tx_clk_i(tx_clk), .int_phy_irq_i(int_irq),
    .ext_phy_irq_i(ext_irq), .tx_halted_pulse_i(ev[17]), .rx_halted_pulse_i(ev[16]),
    .tx_error_pulse_i(ev[14]), .tx_underrun_pulse_i(ev[13]),
    .tx_overrun_pulse_i(ev[12]), .rx_drop_pulse_i(ev[11]), .gpio_pin_i(pins),
    .gpio_int_en_i(en), .mac_reset_o(mac_rst), .rx_fifo_flush_o(flush),
    .pin_wake_o(wake)
  );

  task automatic fail(input string what);
    begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : fail

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      checks++;
      if (got !== exp)
        fail($sformatf("%s got %h exp %h", what, got, exp));
    end
  endtask : chk32

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    begin
      checks++;
      if (got !== exp)
        fail($sformatf("%s resp %h exp %h", what, got, exp));
    end
  endtask : chk_resp

  task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
    begin
      checks++;
      if (got < lo || got > hi)
        fail($sformatf("%s count %0d not in %0d..%0d", what, got, lo, hi));
    end
  endtask : chk_cnt

  // bready held from the start; the master never counts on a latency
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    int k;
    begin
      k = 0;
      @(posedge clock_i);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
        @(posedge clock_i);
        k++;
        if (awvalid && awready === 1'b1)
          awvalid <= 1'b0;
        if (wvalid && wready === 1'b1)
          wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && k < 40);
      bready <= 1'b0;
      if (k >= 40)
        fail("write hung");
      chk_resp(bresp, er, "write");
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    begin
      k = 0;
      @(posedge clock_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
        @(posedge clock_i);
        k++;
        if (arvalid && arready === 1'b1)
          arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && k < 40);
      rready <= 1'b0;
      if (k >= 40)
        fail("read hung");
      chk32(rdata, e, $sformatf("read %h", a));
      chk_resp(rresp, er, "read");
    end
  endtask : rd

  // pulse from tb drives one cycle, then counts how long MAC reset stays on
  task automatic wd_run(input bit toggle, input bit use_tx, output int cnt);
    begin
      cnt = 0;
      @(posedge clock_i);
      mac_req <= 1'b1;
      @(posedge clock_i);
      mac_req <= 1'b0;
      @(posedge clock_i);
      chk32({31'h0, mac_rst}, 32'h1, "mac reset on");
      while (mac_rst === 1'b1 && cnt < 200)
      begin
        @(posedge clock_i);
        cnt++;
        if (toggle && cnt % 4 == 0)
        begin
          if (use_tx)
            tx_clk <= ~tx_clk;
          else
            rx_clk <= ~rx_clk;
        end
      end
    end
  endtask : wd_run

  task automatic stop_test;
    begin
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask : stop_test

  initial
  begin
    #(50 * 30000);
    fail("timeout");
    stop_test();
  end

  initial
  begin
    seed = $urandom(90646);
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(8'h00, {MODEL, REV}, OK);
    wr(8'h00, 32'hFFFFFFFF, OK);
    rd(8'h00, {MODEL, REV}, OK);
    rd(8'h04, 32'h0, ERR);
    wr(8'h10, 32'hFFFFFFFF, ERR);
    exp_s = 32'h0;
    rd(8'h08, exp_s, OK);
    wr(8'h08, 32'h0, OK);
    // frozen clock enable drops a pulse; a cleared strobe lane keeps a flag
    ce <= 1'b0;
    ev <= 7'h01;
    @(posedge clock_i);
    ce <= 1'b1;
    ev <= 7'h00;
    rd(8'h08, 32'h0, OK);
    ev <= 7'h01;
    @(posedge clock_i);
    ev <= 7'h00;
    strb <= 4'hD;
    wr(8'h08, 32'h800, OK);
    strb <= 4'hF;
    rd(8'h08, 32'h800, OK);
    wr(8'h08, 32'h800, OK);
    rd(8'h08, 32'h0, OK);
    // random events set, random words clear; the model tracks sticky bits
    repeat (10)
    begin
      @(posedge clock_i);
      ev <= 7'($urandom) & 7'h6F;
      @(posedge clock_i);
      exp_s[17:11] = exp_s[17:11] | ev;
      ev <= 7'h00;
      repeat (3) @(posedge clock_i);
      rd(8'h08, exp_s, OK);
      d = $urandom;
      wr(8'h08, d, OK);
      exp_s[17:11] = exp_s[17:11] & ~d[17:11];
      rd(8'h08, exp_s, OK);
    end
    // pin flags: reset value follows pins, level holds against clears
    pins <= 11'($urandom);
    en <= 11'($urandom);
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(8'h08, {21'h0, pins & en}, OK);
    rd(8'h08, {21'h0, pins & en}, OK);
    chk32({21'h0, wake}, {21'h0, pins & en}, "wake set");
    wr(8'h08, 32'h7FF, OK);
    rd(8'h08, {21'h0, pins & en}, OK);
    d = {21'h0, pins & en};
    pins <= 11'h000;
    repeat (6) @(posedge clock_i);
    rd(8'h08, d, OK);
    wr(8'h08, 32'h7FF, OK);
    rd(8'h08, 32'h0, OK);
    chk32({21'h0, wake}, 32'h0, "wake cleared");
    en <= 11'h7FF;
    // phy bit is read-only and follows the selected line
    int_irq <= 1'b1;
    repeat (6) @(posedge clock_i);
    rd(8'h08, 32'h8000, OK);
    wr(8'h40, 32'h1, OK);
    rd(8'h08, 32'h0, OK);
    ext_irq <= 1'b1;
    repeat (6) @(posedge clock_i);
    wr(8'h08, 32'h8000, OK);
    rd(8'h08, 32'h8000, OK);
    wr(8'h40, 32'h0, OK);
    int_irq <= 1'b0;
    ext_irq <= 1'b0;
    // flush pulses once per written one, never on a zero
    f0 = flush_cnt;
    wr(8'h0C, 32'hFFFFFFFF, OK);
    wr(8'h0C, 32'h0, OK);
    repeat (2) @(posedge clock_i);
    chk_cnt(flush_cnt - f0, 1, 1, "flush pulses");
    rd(8'h0C, 32'h0, OK);
    // watchdog with silent phy clocks, then with a running one
    wd_run(1'b0, 1'b0, n);
    chk_cnt(n, WD, WD, "watchdog expiry");
    rd(8'h08, 32'h40000, OK);
    wr(8'h08, 32'h40000, OK);
    rd(8'h08, 32'h0, OK);
    wd_run(1'b1, 1'b0, n);
    chk_cnt(n, 1, WD - 10, "clocked release");
    rd(8'h08, 32'h0, OK);
    wd_run(1'b1, 1'b1, n);
    chk_cnt(n, 1, WD - 10, "tx clocked release");
    rd(8'h08, 32'h0, OK);
    stop_test();
  end
endmodule : testbench
